// ---- stidl_top.sv ----
// Purpose: Sync serial line control: idle fill, half duplex receive gating, maintenance loop.
// Assumes: Modem clocks and clear to send are asynchronous pins sampled by hclk.
// Notes:   Characters are 8 bits; a trailing marker bit flags the shifter empty.
`timescale 1ns/10ps
`default_nettype none
`include "stidl_params.svh"

// Contract
// - Idle fill set keeps shifting qualified and send request held.
// - Pending character feeds shifter with buffer bits; otherwise sync pattern.
// - Idle fill, no character: sync loaded on next clock after shifter empties.
// - Idle fill set while inactive raises send request on transmit clock.
// - After clear to send, sync sent and reloaded each character until cleared.
// - Half duplex blocks receive clock while send request is asserted.
// - Receive control bit 2 loops transmit data into the receiver.
// - Loop mode simulates clear to send.
// - Loop mode replaces both modem clocks with internal 3000 Hz clock.
// - Option declares receiver in sync after a single sync character.
// - Without idle fill and no character, send request drops at character end.
// - Loading buffer into shifter sets transmit done and may interrupt.
module stidl_top (
   // AHB-Lite clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Modem
   input  wire logic        tx_clk_pin,
   input  wire logic        rx_clk_pin,
   input  wire logic        cts_pin,
   input  wire logic        rx_data_pin,
   output logic             rts_pin,
   output logic             tx_data_pin,
   // Interrupt
   output logic             irq
);
   localparam int LOOP_HALF = `STIDL_LOOP_HALF;

   stidl_pkg::stidl_ctrl_t      ctrl_reg, ctrl_next, ctrl_tx_reg, ctrl_tx_next;
   stidl_pkg::stidl_tx_state_t  tx_state_reg, tx_state_next;
   logic [7:0]  hold_reg, hold_next, sync_reg, sync_next;
   logic        pend_reg, pend_next, rts_reg, rts_next;
   logic [8:0]  shift_reg, shift_next;
   logic        txd_reg, txd_next;
   logic [7:0]  rxsh_reg, rxsh_next, rbuf_reg, rbuf_next;
   logic [3:0]  rxcnt_reg, rxcnt_next;
   logic [1:0]  rx_sync_cnt_reg, rx_sync_cnt_next;
   logic        in_sync_reg, in_sync_next;
   logic [`STIDL_EV_W-1:0] ist_reg, ist_next, ien_reg, ien_next;
   logic [15:0] lcnt_reg, lcnt_next;
   logic        lclk_reg, lclk_next;
   logic        lrise, lfall;
   logic        ap_sel_reg, ap_wr_reg;
   logic [7:0]  ap_addr_reg;
   logic        tx_fall, rx_rise, cts_lvl, rxd_lvl;
   logic        tclk_fall, rclk_rise, cts_eff, rxd_eff;
   logic        wr_en, ld_hold, ev_tx_done, ev_rx_done, empty;

   stidl_edge u_txc (.clk(hclk), .rst_n(hresetn), .pin(tx_clk_pin), .level(), .rise(), .fall(tx_fall));
   stidl_edge u_rxc (.clk(hclk), .rst_n(hresetn), .pin(rx_clk_pin), .level(), .rise(rx_rise), .fall());
   stidl_edge u_cts (.clk(hclk), .rst_n(hresetn), .pin(cts_pin), .level(cts_lvl), .rise(), .fall());
   stidl_edge u_rxd (.clk(hclk), .rst_n(hresetn), .pin(rx_data_pin), .level(rxd_lvl), .rise(), .fall());

   // Loop clock divider gives 3000 Hz as enable pulses.
   always_comb begin
      lcnt_next = lcnt_reg + 16'h0001;
      lclk_next = lclk_reg;
      if (lcnt_reg == 16'(LOOP_HALF - 1)) begin
         lcnt_next = 16'h0000;
         lclk_next = ~lclk_reg;
      end
   end
   assign lrise = (lcnt_reg == 16'(LOOP_HALF - 1)) & ~lclk_reg;
   assign lfall = (lcnt_reg == 16'(LOOP_HALF - 1)) & lclk_reg;

   assign tclk_fall = ctrl_reg.maint ? lfall : tx_fall;
   // Receive clock is suppressed while sending in half duplex.
   assign rclk_rise = (ctrl_reg.maint ? lrise : rx_rise) & ~(ctrl_tx_reg.half_duplex & rts_reg);
   assign cts_eff   = ctrl_reg.maint | cts_lvl;
   assign rxd_eff   = ctrl_reg.maint ? txd_reg : rxd_lvl;

   // AHB-Lite: zero wait states, always OKAY.
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign wr_en     = ap_sel_reg & ap_wr_reg;
   assign ld_hold   = wr_en & (ap_addr_reg == `STIDL_OFS_TX_HOLD_BUF);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_sel_reg  <= 1'b0;
         ap_wr_reg   <= 1'b0;
         ap_addr_reg <= 8'h00;
      end else if (hready) begin
         ap_sel_reg  <= hsel & htrans[1];
         ap_wr_reg   <= hwrite;
         ap_addr_reg <= haddr;
      end
   end

   always_comb begin
      hrdata = 32'h00000000;
      if (ap_sel_reg & ~ap_wr_reg) begin
         unique case (ap_addr_reg)
            `STIDL_OFS_TX_CTRL_STAT: begin
               hrdata[`STIDL_TC_IDLE_FILL] = ctrl_reg.idle_fill;
               hrdata[`STIDL_TC_CHAR_PEND] = pend_reg;
               hrdata[`STIDL_TC_ACTIVE]    = (tx_state_reg == stidl_pkg::STIDL_TX_SHIFT);
               hrdata[`STIDL_TC_RTS]       = rts_reg;
               hrdata[`STIDL_TC_CTS]       = cts_eff;
            end
            `STIDL_OFS_RX_CTRL_STAT: begin
               hrdata[`STIDL_RC_HALF_DUPLEX] = ctrl_reg.half_duplex;
               hrdata[`STIDL_RC_SINGLE_SYNC] = ctrl_reg.single_sync;
               hrdata[`STIDL_RC_MAINT]       = ctrl_reg.maint;
               hrdata[`STIDL_RC_IN_SYNC]     = in_sync_reg;
            end
            `STIDL_OFS_TX_HOLD_BUF: hrdata[7:0] = hold_reg;
            `STIDL_OFS_SYNC:     hrdata[7:0] = sync_reg;
            `STIDL_OFS_RBUF:     hrdata[7:0] = rbuf_reg;
            `STIDL_OFS_IRQ_STAT: hrdata[`STIDL_EV_W-1:0] = ist_reg;
            `STIDL_OFS_IRQ_EN:   hrdata[`STIDL_EV_W-1:0] = ien_reg;
            default:             hrdata = 32'h00000000;
         endcase
      end
   end

   // Register writes and interrupt status.
   always_comb begin
      ctrl_next = ctrl_reg;
      hold_next = hold_reg;
      sync_next = sync_reg;
      ien_next  = ien_reg;
      ist_next  = ist_reg;
      if (wr_en) begin
         unique case (ap_addr_reg)
            `STIDL_OFS_TX_CTRL_STAT: ctrl_next.idle_fill = hwdata[`STIDL_TC_IDLE_FILL];
            `STIDL_OFS_RX_CTRL_STAT: begin
               ctrl_next.half_duplex = hwdata[`STIDL_RC_HALF_DUPLEX];
               ctrl_next.single_sync = hwdata[`STIDL_RC_SINGLE_SYNC];
               ctrl_next.maint       = hwdata[`STIDL_RC_MAINT];
            end
            `STIDL_OFS_TX_HOLD_BUF: hold_next = hwdata[7:0];
            `STIDL_OFS_SYNC:    sync_next = hwdata[7:0];
            `STIDL_OFS_IRQ_EN:  ien_next  = hwdata[`STIDL_EV_W-1:0];
            `STIDL_OFS_IRQ_CLR: ist_next  = ist_reg & ~hwdata[`STIDL_EV_W-1:0];
            default: ;
         endcase
      end
      // A new event wins over a clear in the same cycle.
      ist_next = ist_next | {ev_rx_done, ev_tx_done};
   end

   assign irq = |(ist_reg & ien_reg);

   // Transmitter. The marker bit in shift_reg[8] trails the data; empty when only it remains in bit 0.
   assign empty = (shift_reg[8:1] == 8'h00);

   always_comb begin
      tx_state_next = tx_state_reg;
      ctrl_tx_next  = ctrl_tx_reg;
      pend_next     = pend_reg | ld_hold;
      rts_next      = rts_reg;
      shift_next    = shift_reg;
      txd_next      = txd_reg;
      ev_tx_done    = 1'b0;
      if (tclk_fall) begin
         ctrl_tx_next = ctrl_reg;
         unique case (tx_state_reg)
            stidl_pkg::STIDL_TX_IDLE: begin
               if (pend_reg | ctrl_reg.idle_fill) begin
                  rts_next      = 1'b1;
                  tx_state_next = stidl_pkg::STIDL_TX_WAIT;
               end
            end
            stidl_pkg::STIDL_TX_WAIT: begin
               if (!(pend_reg | ctrl_tx_reg.idle_fill)) begin
                  rts_next      = 1'b0;
                  tx_state_next = stidl_pkg::STIDL_TX_IDLE;
               end else if (cts_eff) begin
                  shift_next    = 9'h001;
                  tx_state_next = stidl_pkg::STIDL_TX_SHIFT;
               end
            end
            stidl_pkg::STIDL_TX_SHIFT: begin
               if (empty) begin
                  if (pend_reg) begin
                     shift_next = {1'b1, hold_reg};
                     pend_next  = ld_hold;
                     ev_tx_done = 1'b1;
                  end else if (ctrl_tx_reg.idle_fill & cts_eff) begin
                     shift_next = {1'b1, sync_reg};
                  end else begin
                     rts_next      = 1'b0;
                     tx_state_next = stidl_pkg::STIDL_TX_IDLE;
                  end
                  txd_next = 1'b1;
                  if (pend_reg | (ctrl_tx_reg.idle_fill & cts_eff)) begin
                     txd_next = pend_reg ? hold_reg[0] : sync_reg[0];
                  end
                  if (pend_reg | (ctrl_tx_reg.idle_fill & cts_eff)) begin
                     shift_next = {1'b0, shift_next[8:1]};
                  end
               end else begin
                  txd_next   = shift_reg[0];
                  shift_next = {1'b0, shift_reg[8:1]};
               end
               if (ctrl_tx_reg.idle_fill) begin
                  rts_next = (tx_state_next != stidl_pkg::STIDL_TX_IDLE);
               end
            end
            default: tx_state_next = stidl_pkg::STIDL_TX_IDLE;
         endcase
      end
   end

   // Receiver: hunt for sync, then assemble characters.
   always_comb begin
      rxsh_next        = rxsh_reg;
      rxcnt_next       = rxcnt_reg;
      rbuf_next        = rbuf_reg;
      rx_sync_cnt_next = rx_sync_cnt_reg;
      in_sync_next     = in_sync_reg;
      ev_rx_done       = 1'b0;
      if (rclk_rise) begin
         rxsh_next = {rxd_eff, rxsh_reg[7:1]};
         if (!in_sync_reg) begin
            if (rxsh_next == sync_reg) begin
               if (ctrl_reg.single_sync | (rx_sync_cnt_reg == 2'd1)) begin
                  in_sync_next = 1'b1;
               end
               rx_sync_cnt_next = rx_sync_cnt_reg + 2'd1;
               rxcnt_next       = 4'h0;
            end else if (rxcnt_reg == 4'h7) begin
               rx_sync_cnt_next = 2'd0;
               rxcnt_next       = 4'h0;
            end else begin
               rxcnt_next = rxcnt_reg + 4'h1;
            end
         end else if (rxcnt_reg == 4'h7) begin
            rxcnt_next = 4'h0;
            rbuf_next  = rxsh_next;
            ev_rx_done = 1'b1;
         end else begin
            rxcnt_next = rxcnt_reg + 4'h1;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_reg        <= '0;
         ctrl_tx_reg     <= '0;
         hold_reg        <= 8'h00;
         sync_reg        <= `STIDL_SYNC_RESET;
         ien_reg         <= '0;
         ist_reg         <= '0;
         tx_state_reg    <= stidl_pkg::STIDL_TX_IDLE;
         pend_reg        <= 1'b0;
         rts_reg         <= 1'b0;
         shift_reg       <= 9'h000;
         txd_reg         <= 1'b1;
         rxsh_reg        <= 8'h00;
         rxcnt_reg       <= 4'h0;
         rbuf_reg        <= 8'h00;
         rx_sync_cnt_reg <= 2'd0;
         in_sync_reg     <= 1'b0;
         lcnt_reg        <= 16'h0000;
         lclk_reg        <= 1'b0;
      end else begin
         ctrl_reg        <= ctrl_next;
         ctrl_tx_reg     <= ctrl_tx_next;
         hold_reg        <= hold_next;
         sync_reg        <= sync_next;
         ien_reg         <= ien_next;
         ist_reg         <= ist_next;
         tx_state_reg    <= tx_state_next;
         pend_reg        <= pend_next;
         rts_reg         <= rts_next;
         shift_reg       <= shift_next;
         txd_reg         <= txd_next;
         rxsh_reg        <= rxsh_next;
         rxcnt_reg       <= rxcnt_next;
         rbuf_reg        <= rbuf_next;
         rx_sync_cnt_reg <= rx_sync_cnt_next;
         in_sync_reg     <= in_sync_next;
         lcnt_reg        <= lcnt_next;
         lclk_reg        <= lclk_next;
      end
   end

   // Loop mode keeps the modem line quiet.
   assign rts_pin     = rts_reg & ~ctrl_reg.maint;
   assign tx_data_pin = ctrl_reg.maint ? 1'b1 : txd_reg;

   property p_idle_rts;
      @(posedge hclk) disable iff (!hresetn)
      (tx_state_reg == stidl_pkg::STIDL_TX_SHIFT) && ctrl_tx_reg.idle_fill && tclk_fall |=> rts_reg;
   endproperty
   a_idle_rts: assert property (p_idle_rts) else $error("send request dropped under idle fill");

   property p_data_load;
      @(posedge hclk) disable iff (!hresetn)
      (tx_state_reg == stidl_pkg::STIDL_TX_SHIFT) && empty && pend_reg && tclk_fall
         |=> shift_reg[7:0] == {1'b1, $past(hold_reg[7:1])};
   endproperty
   a_data_load: assert property (p_data_load) else $error("buffer not loaded into shifter");

   property p_sync_load;
      @(posedge hclk) disable iff (!hresetn)
      (tx_state_reg == stidl_pkg::STIDL_TX_SHIFT) && empty && !pend_reg && ctrl_tx_reg.idle_fill
         && cts_eff && tclk_fall |=> txd_reg == $past(sync_reg[0]);
   endproperty
   a_sync_load: assert property (p_sync_load) else $error("sync pattern not sent on idle");

   property p_start;
      @(posedge hclk) disable iff (!hresetn)
      (tx_state_reg == stidl_pkg::STIDL_TX_IDLE) && ctrl_reg.idle_fill && tclk_fall |=> rts_reg;
   endproperty
   a_start: assert property (p_start) else $error("idle fill did not raise send request");

   property p_half;
      @(posedge hclk) disable iff (!hresetn)
      ctrl_tx_reg.half_duplex && rts_reg |=> $stable(rxsh_reg);
   endproperty
   a_half: assert property (p_half) else $error("receive clock passed while sending");

   property p_cts_sim;
      @(posedge hclk) disable iff (!hresetn)
      ctrl_reg.maint |-> cts_eff && !rts_pin;
   endproperty
   a_cts_sim: assert property (p_cts_sim) else $error("loop mode lacks simulated clear to send");

   property p_drop;
      @(posedge hclk) disable iff (!hresetn)
      (tx_state_reg == stidl_pkg::STIDL_TX_SHIFT) && empty && !pend_reg && !ctrl_tx_reg.idle_fill
         && tclk_fall |=> !rts_reg && tx_state_reg == stidl_pkg::STIDL_TX_IDLE;
   endproperty
   a_drop: assert property (p_drop) else $error("send request not dropped at end");

   property p_done;
      @(posedge hclk) disable iff (!hresetn)
      ev_tx_done |=> ist_reg[`STIDL_EV_TX_DONE] && (!ien_reg[`STIDL_EV_TX_DONE] || irq);
   endproperty
   a_done: assert property (p_done) else $error("transmit done not flagged");

   property p_loop_clk;
      @(posedge hclk) disable iff (!hresetn)
      ctrl_reg.maint && !lfall |=> $stable(tx_state_reg) && $stable(shift_reg);
   endproperty
   a_loop_clk: assert property (p_loop_clk) else $error("modem clock used in loop mode");
endmodule
`default_nettype wire

// ---- stidl_params.svh ----
// Purpose: Offsets, field positions, reset values and timing counts of the sync line interface.
// Assumes: 200 MHz hclk, AHB-Lite register access, one aligned word per register.
// Notes:   Definitions only.
`ifndef STIDL_PARAMS_SVH
`define STIDL_PARAMS_SVH

`define STIDL_OFS_TX_CTRL_STAT 8'h00
`define STIDL_OFS_RX_CTRL_STAT 8'h04
`define STIDL_OFS_TX_HOLD_BUF  8'h08
`define STIDL_OFS_SYNC        8'h0C
`define STIDL_OFS_RBUF        8'h10
`define STIDL_OFS_IRQ_STAT    8'h14
`define STIDL_OFS_IRQ_EN      8'h18
`define STIDL_OFS_IRQ_CLR     8'h1C

`define STIDL_TC_IDLE_FILL    0
`define STIDL_TC_CHAR_PEND    1
`define STIDL_TC_ACTIVE       2
`define STIDL_TC_RTS          3
`define STIDL_TC_CTS          4

`define STIDL_RC_HALF_DUPLEX  0
`define STIDL_RC_SINGLE_SYNC  1
`define STIDL_RC_MAINT        2
`define STIDL_RC_IN_SYNC      3

`define STIDL_EV_TX_DONE      0
`define STIDL_EV_RX_DONE      1
`define STIDL_EV_W            2

`define STIDL_SYNC_RESET      8'h96
`define STIDL_CLK_HZ          200000000
`define STIDL_LOOP_HZ         3000
`define STIDL_LOOP_HALF       ((`STIDL_CLK_HZ / `STIDL_LOOP_HZ) / 2)

`endif

// ---- stidl_pkg.sv ----
// Purpose: Types shared by the sync line interface files.
// Assumes: Constants live in stidl_params.svh.
// Notes:   Types only.
`default_nettype none
package stidl_pkg;
   typedef struct packed {
      logic idle_fill;
      logic half_duplex;
      logic single_sync;
      logic maint;
   } stidl_ctrl_t;

   typedef enum logic [2:0] {
      STIDL_TX_IDLE  = 3'b001,
      STIDL_TX_WAIT  = 3'b010,
      STIDL_TX_SHIFT = 3'b100
   } stidl_tx_state_t;
endpackage
`default_nettype wire

// ---- stidl_edge.sv ----
// Purpose: Synchronise a pin and give one-cycle rise and fall pulses.
// Assumes: Input is asynchronous to clk.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/10ps
`default_nettype none
module stidl_edge (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Pin and results
   input  wire logic pin,
   output logic      level,
   output logic      rise,
   output logic      fall
);
   logic       first_reg;
   logic       second_reg;
   logic       prev_reg;
   logic [1:0] warm_reg;

   // Edges are held off until the history stage holds a real sample, so the
   // reset value can never pose as a transition of an idling pin.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         first_reg  <= 1'b0;
         second_reg <= 1'b0;
         prev_reg   <= 1'b0;
         warm_reg   <= 2'h0;
      end else begin
         first_reg  <= pin;
         second_reg <= first_reg;
         prev_reg   <= second_reg;
         if (warm_reg != 2'h3) begin
            warm_reg <= warm_reg + 2'h1;
         end
      end
   end

   assign level = second_reg;
   assign rise  = second_reg & ~prev_reg & (warm_reg == 2'h3);
   assign fall  = ~second_reg & prev_reg & (warm_reg == 2'h3);
endmodule
`default_nettype wire

// ---- stidl_modem_model.sv ----
// Purpose: Behavioural synchronous modem on the line side of the sync interface.
// Assumes: Free running line clocks; receive clock shares the transmit clock.
// Notes:   The line data is echoed back, as a remote loop would do.
`timescale 1ns/10ps
`default_nettype none
module stidl_modem_model #(
   parameter int HALF_NS   = 80,
   parameter int CTS_DELAY = 2
) (
   // Line clocks
   output logic      tx_clk,
   output logic      rx_clk,
   // Handshake and data
   input  wire logic rts,
   input  wire logic tx_data,
   output logic      cts,
   output logic      rx_data
);
   int cnt;

   // The odd start offset keeps the line clock out of step with hclk.
   initial begin
      tx_clk = 1'h1;
      cts = 1'h0;
      cnt = 0;
      #37;
      forever #(HALF_NS) tx_clk = ~tx_clk;
   end

   assign rx_clk = tx_clk;
   assign rx_data = tx_data;

   // Clear to send follows request to send after a few clock falls and drops with it.
   always @(negedge tx_clk) begin
      if (rts !== 1'h1) begin
         cnt = 0;
         cts <= 1'h0;
      end else if (cnt < CTS_DELAY) begin
         cnt++;
      end else begin
         cts <= 1'h1;
      end
   end
endmodule
`default_nettype wire

// ---- stidl_top_tb.sv ----
// Purpose: Self-checking bench for the sync line interface top.
// Assumes: The modem model echoes line data and returns clear to send.
// Notes:   The 3000 Hz loop clock is too slow to see a whole looped character.
`timescale 1ns/10ps
`default_nettype none
`include "stidl_params.svh"
module stidl_top_tb;
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic [31:0] exp;
   } stidl_row_t;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        tx_clk;
   logic        rx_clk;
   logic        cts;
   logic        rx_data;
   logic        rts_pin;
   logic        tx_data_pin;
   logic        irq;
   logic [31:0] rd;
   logic        mon_on;
   logic        started;
   logic        bits[$];
   int          mismatches;
   int          compares;
   int          cyc;
   int          bad;
   stidl_row_t  rows[9];

   stidl_top i_stidl_top (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .tx_clk_pin(tx_clk), .rx_clk_pin(rx_clk), .cts_pin(cts), .rx_data_pin(rx_data),
      .rts_pin(rts_pin), .tx_data_pin(tx_data_pin), .irq(irq)
   );

   stidl_modem_model i_stidl_modem_model (
      .tx_clk(tx_clk), .rx_clk(rx_clk), .rts(rts_pin), .tx_data(tx_data_pin), .cts(cts), .rx_data(rx_data)
   );

   initial begin
      hclk = 1'h0;
      forever #2.5 hclk = ~hclk;
   end

   // Line bits are taken mid-bit; a character starts at the first space after the line idles.
   always @(posedge tx_clk) begin
      if (mon_on && (started || tx_data_pin === 1'h0)) begin
         started = 1'h1;
         bits.push_back(tx_data_pin);
      end
   end

   always @(posedge hclk) begin
      cyc = cyc + 1;
      if (cyc == 60000) begin
         mismatches++;
         tally_and_finish();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      rd = hrdata;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string msg);
      xfer(1'h0, a, 32'h0);
      chk(rd & m, e, msg);
   endtask

   task automatic wait_pin(input bit use_irq, input logic v, input int lim);
      int n;
      n = 0;
      while ((use_irq ? irq : rts_pin) !== v && n < lim) begin
         @(posedge hclk);
         n++;
      end
      chk({31'h0, use_irq ? irq : rts_pin}, {31'h0, v}, "pin wait");
   endtask

   task automatic wait_bits(input int n);
      int k;
      k = 0;
      while (bits.size() < n && k < 8000) begin
         @(posedge hclk);
         k++;
      end
   endtask

   task automatic mon_start();
      mon_on = 1'h1;
      started = 1'h0;
      bits.delete();
   endtask

   function automatic logic [31:0] byte_at(input int k);
      logic [31:0] b;
      b = 32'h0;
      for (int i = 0; i < 8; i++) begin
         b[i] = (8 * k + i < bits.size()) ? bits[8 * k + i] : 1'hX;
      end
      return b;
   endfunction

   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   initial begin
      hresetn = 1'h0;
      hsel = 1'h0;
      haddr = 8'h00;
      htrans = 2'h0;
      hwrite = 1'h0;
      hsize = 3'h2;
      hwdata = 32'h0;
      mon_on = 1'h0;
      started = 1'h0;
      mismatches = 0;
      compares = 0;
      cyc = 0;
      rows[0] = '{`STIDL_OFS_SYNC, 32'h5A, 32'h5A};
      rows[1] = '{`STIDL_OFS_SYNC, 32'h96, 32'h96};
      rows[2] = '{`STIDL_OFS_IRQ_EN, 32'h3, 32'h3};
      rows[3] = '{`STIDL_OFS_IRQ_EN, 32'h0, 32'h0};
      rows[4] = '{`STIDL_OFS_RX_CTRL_STAT, 32'h2, 32'h2};
      rows[5] = '{`STIDL_OFS_RX_CTRL_STAT, 32'h0, 32'h0};
      rows[6] = '{`STIDL_OFS_TX_CTRL_STAT, 32'h1E, 32'h0};
      rows[7] = '{`STIDL_OFS_IRQ_STAT, 32'h3, 32'h0};
      rows[8] = '{8'hF0, 32'hFFFFFFFF, 32'h0};
      repeat (2) @(posedge hclk);
      hresetn <= 1'h1;
      rchk(`STIDL_OFS_SYNC, 32'hFFFFFFFF, 32'h96, "sync reset");
      chk({29'h0, rts_pin, tx_data_pin, irq}, 32'h2, "pins after reset");
      chk({31'h0, hresp}, 32'h0, "response");
      foreach (rows[i]) begin
         xfer(1'h1, rows[i].addr, rows[i].wdata);
         rchk(rows[i].addr, 32'hFFFFFFFF, rows[i].exp, "register row");
      end
      // Half duplex: idle sync goes out but the receiver must hear nothing.
      xfer(1'h1, `STIDL_OFS_RX_CTRL_STAT, 32'h1);
      mon_start();
      xfer(1'h1, `STIDL_OFS_TX_CTRL_STAT, 32'h1);
      wait_pin(1'h0, 1'h1, 3000);
      wait_bits(24);
      for (int k = 0; k < 3; k++) begin
         chk(byte_at(k), 32'h96, "idle sync");
      end
      chk({31'h0, rts_pin}, 32'h1, "send request held");
      rchk(`STIDL_OFS_RX_CTRL_STAT, 32'h8, 32'h0, "half duplex sync");
      rchk(`STIDL_OFS_IRQ_STAT, 32'h2, 32'h0, "half duplex rx");
      xfer(1'h1, `STIDL_OFS_TX_CTRL_STAT, 32'h0);
      wait_pin(1'h0, 1'h0, 2000);
      chk(bits.size() % 8, 32'h0, "whole characters");
      // Full duplex: pending character first, then sync fills the gaps.
      xfer(1'h1, `STIDL_OFS_RX_CTRL_STAT, 32'h0);
      mon_start();
      xfer(1'h1, `STIDL_OFS_TX_HOLD_BUF, 32'h3C);
      xfer(1'h1, `STIDL_OFS_TX_CTRL_STAT, 32'h1);
      // One whole sync has reached the receiver here; the default needs two.
      wait_bits(17);
      rchk(`STIDL_OFS_RX_CTRL_STAT, 32'h8, 32'h0, "one sync not enough");
      wait_bits(32);
      chk(byte_at(0), 32'h3C, "data first");
      for (int k = 1; k < 4; k++) begin
         chk(byte_at(k), 32'h96, "sync fill");
      end
      rchk(`STIDL_OFS_RX_CTRL_STAT, 32'h8, 32'h8, "full duplex sync");
      rchk(`STIDL_OFS_IRQ_STAT, 32'h1, 32'h1, "done status");
      chk({31'h0, irq}, 32'h0, "masked irq");
      xfer(1'h1, `STIDL_OFS_TX_CTRL_STAT, 32'h0);
      wait_pin(1'h0, 1'h0, 2000);
      chk(bits.size() % 8, 32'h0, "whole characters");
      xfer(1'h1, `STIDL_OFS_IRQ_CLR, 32'h3);
      // Back to back characters without idle fill, refilled on the done interrupt.
      xfer(1'h1, `STIDL_OFS_IRQ_EN, 32'h1);
      mon_start();
      xfer(1'h1, `STIDL_OFS_TX_HOLD_BUF, 32'h3C);
      wait_pin(1'h1, 1'h1, 3000);
      xfer(1'h1, `STIDL_OFS_IRQ_CLR, 32'h1);
      wait_pin(1'h1, 1'h0, 10);
      xfer(1'h1, `STIDL_OFS_TX_HOLD_BUF, 32'h81);
      wait_pin(1'h0, 1'h0, 3000);
      chk(bits.size(), 32'h10, "two characters only");
      chk(byte_at(0), 32'h3C, "first char");
      chk(byte_at(1), 32'h81, "second char");
      chk({31'h0, irq}, 32'h1, "second done");
      xfer(1'h1, `STIDL_OFS_IRQ_CLR, 32'h1);
      // Loop mode keeps the modem side quiet and ignores the modem clocks.
      xfer(1'h1, `STIDL_OFS_RX_CTRL_STAT, 32'h4);
      xfer(1'h1, `STIDL_OFS_TX_HOLD_BUF, 32'h3C);
      bad = 0;
      repeat (2000) begin
         @(posedge hclk);
         if (rts_pin !== 1'h0 || tx_data_pin !== 1'h1) begin
            bad++;
         end
      end
      chk(bad, 32'h0, "loop pins quiet");
      rchk(`STIDL_OFS_TX_CTRL_STAT, 32'h4, 32'h0, "modem clock ignored");
      rchk(`STIDL_OFS_RX_CTRL_STAT, 32'h4, 32'h4, "loop mode set");
      // A second reset in mid-run, then lock on a single sync character.
      hresetn <= 1'h0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'h1;
      rchk(`STIDL_OFS_RX_CTRL_STAT, 32'hFFFFFFFF, 32'h0, "control after reset");
      chk({29'h0, rts_pin, tx_data_pin, irq}, 32'h2, "pins after second reset");
      xfer(1'h1, `STIDL_OFS_RX_CTRL_STAT, 32'h2);
      mon_start();
      xfer(1'h1, `STIDL_OFS_TX_CTRL_STAT, 32'h1);
      wait_bits(9);
      rchk(`STIDL_OFS_RX_CTRL_STAT, 32'h8, 32'h8, "single sync lock");
      tally_and_finish();
   end
endmodule
`default_nettype wire
